// ---- hdl/fifo_sim_cfg.svh ----
// Address windows, register indices, field positions and reset values of the FIFO simulator board
`ifndef FIFO_SIM_CFG_SVH
`define FIFO_SIM_CFG_SVH

`define FS_WIN_HI          19
`define FS_WIN_LO          16
`define FS_MEM_WIN         4'h1
`define FS_IO_WIN          4'h2
`define FS_IO_HI           4
`define FS_IO_LO           2
`define FS_WADDR_HI        12
`define FS_WADDR_LO        2
`define FS_HTRANS_ACTIVE   1

`define FS_REG_CONTROL     3'h0
`define FS_REG_COUNTER     3'h1
`define FS_REG_STATUS      3'h2
`define FS_REG_IRQ_STATUS  3'h3
`define FS_REG_IRQ_CLEAR   3'h4
`define FS_REG_IRQ_ENABLE  3'h5

`define FS_CNT_CLEAR_BIT   0
`define FS_CNT_FULL_BIT    11
`define FS_CNT_STEP        12'h001
`define FS_CNT_RESET       12'h000
`define FS_NIB_HI          3
`define FS_CTRL_RESET      32'h0000_0000
`define FS_IRQ_RESET       3'h0
`define FS_WORD_ZERO       32'h0000_0000
`define FS_ADDR_ZERO       20'h0_0000
`define FS_SYNC_ZERO       3'h0
`define FS_SYNC_LAST       2
`define FS_SYNC_MID        1
`define FS_LATCH_RESET     14'h0000

`endif

// ---- hdl/fifo_sim_pkg.sv ----
// Types shared by the FIFO simulator board logic
package fifo_sim_pkg;

    typedef enum logic [1:0] {
        BS_NORMAL = 2'b00,
        BS_FIXED  = 2'b01,
        BS_SPARE2 = 2'b10,
        BS_SPARE3 = 2'b11
    } board_state_t;

    typedef enum logic {
        BUS_IDLE = 1'b0,
        BUS_DATA = 1'b1
    } bus_phase_t;

    typedef struct packed {
        logic [22:0]  unused;
        logic         attention;
        logic [3:0]   nibble;
        logic         spare;
        board_state_t board_state;
        logic         src_host;
    } ctrl_t;

    typedef struct packed {
        logic link_read;
        logic link_write;
        logic full;
    } irq_t;

    typedef struct packed {
        bus_phase_t   phase;
        logic         ready;
        logic [31:0]  rdata;
        logic         hresp;
        logic         ack;
        logic [19:0]  addr;
        logic         write;
        logic         mem_hit;
        logic         io_hit;
        ctrl_t        ctrl;
        irq_t         irq_status;
        irq_t         irq_enable;
        logic         irq;
        logic [11:0]  counter;
        logic [13:0]  status_latch;
        logic [2:0]   clk_sync;
        logic [2:0]   wr_sync;
        logic [31:0]  d1;
        logic [31:0]  d2;
        logic [31:0]  d3;
        logic         clk_level;
        logic         pll_a;
        logic         pll_b;
        logic [31:0]  link_out;
        logic         link_oe;
        logic         write_gate;
        logic         attention;
        logic         lane_lo;
        logic         lane_hi;
        logic         host_dir;
    } state_t;

endpackage

// ---- hdl/fifo_memory_simulator.sv ----
// FIFO memory simulator: 2K x 32 RAM, address counter, link side and AHB-Lite host side
//
// Notes on behaviour
// - 12-bit counter steps on each increment pulse until its top bit reports full, then holds.
// - RAM holds 2K words of 32 bits as the simulated FIFO store.
// - Source select picks host word address or counter address for the RAM.
// - Low four counter address bits pass a selector steered by board state and gates.
// - With board select, address bits 19..16 decode the memory window.
// - Low address bits decode the register window accesses.
// - Link write request comes from the synchronised link control line.
// - Two internal strobes derive from link clock edges and time the control logic.
// - Control outputs depend on link clock, write request, window hits and full.
// - Host accesses served by the board get an acknowledge reply.
// - An attention signal toward the unit under test comes from control logic.
// - Writes store the word at the chosen address using both half strobes.
// - Link words move between RAM and unit, direction set by write gate.
// - Host data lanes, direction and lane enables come from control logic.
// - Status latch holds counter address, full and board state for host reads.
// - Counter is cleared by a reset pulse and advanced by increment pulses.
`timescale 1ns/10ps
`include "fifo_sim_cfg.svh"

module fifo_memory_simulator
    import fifo_sim_pkg::*;
(
    input  wire logic        I_CLK,
    input  wire logic        I_RESET,
    input  wire logic        I_HSEL,
    input  wire logic [31:0] I_HADDR,
    input  wire logic [1:0]  I_HTRANS,
    input  wire logic        I_HWRITE,
    input  wire logic [2:0]  I_HSIZE,
    input  wire logic [31:0] I_HWDATA,
    input  wire logic        I_HREADY,
    output logic             O_HREADYOUT,
    output logic [31:0]      O_HRDATA,
    output logic             O_HRESP,
    input  wire logic        I_BOARD_SELECT,
    output logic             O_HOST_ACK,
    output logic             O_LANE_LOW_EN,
    output logic             O_LANE_HIGH_EN,
    output logic             O_HOST_DIR,
    output logic             O_IRQ,
    input  wire logic        I_LINK_CLK,
    input  wire logic        I_LINK_WRITE,
    input  wire logic [31:0] I_LINK_DATA,
    output logic [31:0]      O_LINK_DATA,
    output logic             O_LINK_DATA_OE,
    output logic             O_LINK_WRITE_GATE,
    output logic             O_TARGET_ATTENTION
);

    state_t      s;
    state_t      next_s;

    logic [31:0] ram [0:2047];

    logic        ram_we;
    logic        wstrobe_h;
    logic        wstrobe_l;
    logic [10:0] ram_addr;
    logic [31:0] ram_wdata;
    logic [31:0] ram_rd;
    logic [10:0] cnt_addr;
    logic [10:0] host_waddr;
    logic        out_gate;
    logic        cnt_clear;
    logic        cnt_inc;
    logic        link_op;
    logic        host_go;
    logic        capture;
    irq_t        irq_set;
    irq_t        irq_clr;

    function automatic logic win_hit(input logic [31:0] addr, input logic [3:0] win, input logic sel);
        win_hit = sel && (addr[`FS_WIN_HI:`FS_WIN_LO] == win);
    endfunction

    function automatic logic [11:0] step(input logic [11:0] cnt);
        step = cnt + `FS_CNT_STEP;
    endfunction

    assign ram_rd = ram[ram_addr];

    always_comb
    begin
        next_s     = s;
        ram_we     = 1'b0;
        wstrobe_h  = 1'b0;
        wstrobe_l  = 1'b0;
        ram_wdata  = `FS_WORD_ZERO;
        cnt_clear  = 1'b0;
        cnt_inc    = 1'b0;
        irq_set    = `FS_IRQ_RESET;
        irq_clr    = `FS_IRQ_RESET;

        // Link pins cross into our clock through three stages
        next_s.clk_sync = {s.clk_sync[`FS_SYNC_MID:0], I_LINK_CLK};
        next_s.wr_sync  = {s.wr_sync[`FS_SYNC_MID:0], I_LINK_WRITE};
        next_s.d1       = I_LINK_DATA;
        next_s.d2       = s.d1;
        next_s.d3       = s.d2;

        // Edge strobes once the last two stages agree
        next_s.pll_a = 1'b0;
        next_s.pll_b = 1'b0;
        if (s.clk_sync[`FS_SYNC_LAST] == s.clk_sync[`FS_SYNC_MID] && s.clk_sync[`FS_SYNC_LAST] != s.clk_level)
        begin
            next_s.clk_level = s.clk_sync[`FS_SYNC_LAST];
            next_s.pll_a     = s.clk_sync[`FS_SYNC_LAST];
            next_s.pll_b     = !s.clk_sync[`FS_SYNC_LAST];
        end

        // Write request taken from the synchronised control line
        out_gate   = !s.wr_sync[`FS_SYNC_LAST];
        link_op    = s.pll_a;
        host_waddr = s.addr[`FS_WADDR_HI:`FS_WADDR_LO];

        cnt_addr = s.counter[10:0];
        if (s.ctrl.board_state == BS_FIXED && out_gate)
        begin
            cnt_addr[`FS_NIB_HI:0] = s.ctrl.nibble;
        end

        // Address source multiplexer; link traffic always uses the counter
        ram_addr = (s.ctrl.src_host && !link_op) ? host_waddr : cnt_addr;

        // Link side control from clock edge, write request and full
        if (link_op)
        begin
            cnt_inc = 1'b1;
            if (!out_gate)
            begin
                // Link word stored under both half strobes
                ram_we      = 1'b1;
                wstrobe_h   = 1'b1;
                wstrobe_l   = 1'b1;
                ram_wdata   = s.d3;
                irq_set.link_write = 1'b1;
            end
            else
            begin
                // RAM word presented to the unit
                next_s.link_out   = ram_rd;
                irq_set.link_read = 1'b1;
            end
        end

        // Direction turns on the falling link edge, while the unit holds the bus still
        if (s.pll_b)
        begin
            next_s.link_oe    = out_gate;
            next_s.write_gate = !out_gate;
        end

        // Host data phase waits one cycle when a link edge needs the RAM
        host_go = (s.phase == BUS_DATA) && !link_op;
        next_s.ack      = 1'b0;
        next_s.lane_lo  = 1'b0;
        next_s.lane_hi  = 1'b0;
        if (host_go)
        begin
            next_s.phase = BUS_IDLE;
            next_s.ready = 1'b1;
            next_s.rdata = `FS_WORD_ZERO;
            // Acknowledge only for served window accesses
            next_s.ack   = s.mem_hit || s.io_hit;
            // Lane enables and direction for the host transceiver
            next_s.host_dir = !s.write;
            next_s.lane_lo  = s.mem_hit || s.io_hit;
            next_s.lane_hi  = s.mem_hit || s.io_hit;
            if (s.mem_hit)
            begin
                cnt_inc = !s.ctrl.src_host;
                if (s.write)
                begin
                    // Host word stored under both half strobes
                    ram_we    = 1'b1;
                    wstrobe_h = 1'b1;
                    wstrobe_l = 1'b1;
                    ram_wdata = I_HWDATA;
                end
                else
                begin
                    next_s.rdata = ram_rd;
                end
            end
            else if (s.io_hit)
            begin
                unique case (s.addr[`FS_IO_HI:`FS_IO_LO])
                    `FS_REG_CONTROL:
                    begin
                        if (s.write)
                        begin
                            next_s.ctrl = ctrl_t'(I_HWDATA);
                        end
                        next_s.rdata = s.ctrl;
                    end
                    `FS_REG_COUNTER:
                    begin
                        // Counter reset pulse from a host write
                        cnt_clear    = s.write && I_HWDATA[`FS_CNT_CLEAR_BIT];
                        next_s.rdata = {20'h0_0000, s.counter};
                    end
                    `FS_REG_STATUS:
                    begin
                        next_s.rdata = {18'h0_0000, s.status_latch};
                    end
                    `FS_REG_IRQ_STATUS:
                    begin
                        next_s.rdata = {29'h0000_0000, s.irq_status};
                    end
                    `FS_REG_IRQ_CLEAR:
                    begin
                        if (s.write)
                        begin
                            irq_clr = irq_t'(I_HWDATA[2:0]);
                        end
                    end
                    `FS_REG_IRQ_ENABLE:
                    begin
                        if (s.write)
                        begin
                            next_s.irq_enable = irq_t'(I_HWDATA[2:0]);
                        end
                        next_s.rdata = {29'h0000_0000, s.irq_enable};
                    end
                    default:
                    begin
                        next_s.rdata = `FS_WORD_ZERO;
                    end
                endcase
            end
        end

        // Address phase is taken only while no transfer is pending
        capture = I_HSEL && I_HTRANS[`FS_HTRANS_ACTIVE] && I_HREADY;
        if (capture)
        begin
            next_s.phase   = BUS_DATA;
            next_s.ready   = 1'b0;
            next_s.addr    = I_HADDR[19:0];
            next_s.write   = I_HWRITE;
            // Memory window decode under board select
            next_s.mem_hit = win_hit(I_HADDR, `FS_MEM_WIN, I_BOARD_SELECT);
            next_s.io_hit  = win_hit(I_HADDR, `FS_IO_WIN, I_BOARD_SELECT);
        end

        if (cnt_clear)
        begin
            next_s.counter = `FS_CNT_RESET;
        end
        else if (cnt_inc && !s.counter[`FS_CNT_FULL_BIT])
        begin
            next_s.counter = step(s.counter);
            irq_set.full   = step(s.counter) >> `FS_CNT_FULL_BIT != `FS_CNT_RESET;
        end

        // Latch takes the raw counter, ahead of the nibble selector
        next_s.status_latch = {s.ctrl.board_state, s.counter[`FS_CNT_FULL_BIT], s.counter[10:0]};

        // A new event outranks a clear arriving in the same cycle
        next_s.irq_status = (s.irq_status & ~irq_clr) | irq_set;
        next_s.irq        = |(next_s.irq_status & next_s.irq_enable);

        // Attention toward the unit under test
        next_s.attention = s.ctrl.attention || s.counter[`FS_CNT_FULL_BIT];
        next_s.hresp     = 1'b0;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            s              <= '0;
            s.phase        <= BUS_IDLE;
            s.ready        <= 1'b1;
            s.addr         <= `FS_ADDR_ZERO;
            s.ctrl         <= ctrl_t'(`FS_CTRL_RESET);
            s.irq_status   <= `FS_IRQ_RESET;
            s.irq_enable   <= `FS_IRQ_RESET;
            s.counter      <= `FS_CNT_RESET;
            s.status_latch <= `FS_LATCH_RESET;
            s.clk_sync     <= `FS_SYNC_ZERO;
            s.wr_sync      <= `FS_SYNC_ZERO;
        end
        else
        begin
            s <= next_s;
        end
    end

    // The RAM stays out of the state record: it has no reset and needs its own write port
    always_ff @(posedge I_CLK)
    begin
        if (ram_we && wstrobe_h)
        begin
            ram[ram_addr][31:16] <= ram_wdata[31:16];
        end
        if (ram_we && wstrobe_l)
        begin
            ram[ram_addr][15:0] <= ram_wdata[15:0];
        end
    end

    assign O_HREADYOUT        = s.ready;
    assign O_HRDATA           = s.rdata;
    assign O_HRESP            = s.hresp;
    assign O_HOST_ACK         = s.ack;
    assign O_LANE_LOW_EN      = s.lane_lo;
    assign O_LANE_HIGH_EN     = s.lane_hi;
    assign O_HOST_DIR         = s.host_dir;
    assign O_IRQ              = s.irq;
    assign O_LINK_DATA        = s.link_out;
    assign O_LINK_DATA_OE     = s.link_oe;
    assign O_LINK_WRITE_GATE  = s.write_gate;
    assign O_TARGET_ATTENTION = s.attention;

    a_ack_pulse: assert property (@(posedge I_CLK) disable iff (I_RESET)
        O_HOST_ACK |=> !O_HOST_ACK)
        else $error("acknowledge longer than one clock");

    a_ack_hit_only: assert property (@(posedge I_CLK) disable iff (I_RESET)
        O_HOST_ACK |-> $past(s.phase == BUS_DATA && (s.mem_hit || s.io_hit)) && O_HREADYOUT)
        else $error("acknowledge without a decoded access");

    // Host answer arrives within two cycles
    a_ready_answer: assert property (@(posedge I_CLK) disable iff (I_RESET)
        capture |=> !O_HREADYOUT ##[1:2] O_HREADYOUT)
        else $error("host access not answered in time");

    a_full_hold: assert property (@(posedge I_CLK) disable iff (I_RESET)
        s.counter[`FS_CNT_FULL_BIT] && !cnt_clear |=> s.counter == $past(s.counter))
        else $error("counter moved while full");

    // Counter steps by one on a link edge
    a_counter_step: assert property (@(posedge I_CLK) disable iff (I_RESET)
        s.pll_a && !s.counter[`FS_CNT_FULL_BIT] |=> s.counter == step($past(s.counter)))
        else $error("counter did not advance on link edge");

    a_counter_clear: assert property (@(posedge I_CLK) disable iff (I_RESET)
        cnt_clear |=> s.counter == `FS_CNT_RESET ##1 !s.counter[`FS_CNT_FULL_BIT])
        else $error("counter not cleared");

    // Link write lands at counter address
    a_link_store: assert property (@(posedge I_CLK) disable iff (I_RESET)
        s.pll_a && s.wr_sync[`FS_SYNC_LAST] |-> ram_we && ram_addr == cnt_addr && ram_wdata == s.d3)
        else $error("link word not stored at counter address");

    // Rising edge strobe is single and never coincides with the falling one
    a_edge_strobe: assert property (@(posedge I_CLK) disable iff (I_RESET)
        s.pll_a |-> !s.pll_b ##1 !s.pll_a)
        else $error("link edge strobe malformed");

    // Host address used in host source mode
    a_host_addr: assert property (@(posedge I_CLK) disable iff (I_RESET)
        host_go && s.mem_hit && s.ctrl.src_host |-> ram_addr == s.addr[`FS_WADDR_HI:`FS_WADDR_LO])
        else $error("host word address not selected");

endmodule

// ---- testbench/link_unit.sv ----
// Behavioural unit under test on the far side of the link
`timescale 1ns/10ps

module link_unit
(
    input  wire logic [31:0] i_data,
    output logic             o_clk,
    output logic             o_write,
    output logic [31:0]      o_data
);
    initial
    begin
        o_clk = 1'b0;
        o_write = 1'b0;
        o_data = 32'h0000_0000;
    end

    task automatic put(input logic [31:0] d);
    begin
        o_write <= 1'b1;
        o_data <= d;
        #90 o_clk = 1'b1;
        // Released lines show the inverse, so a late sample never matches
        #80 o_data = ~d;
        #20 o_clk = 1'b0;
        #10;
    end
    endtask

    task automatic get(output logic [31:0] d);
    begin
        o_write <= 1'b0;
        #90 o_clk = 1'b1;
        #100 o_clk = 1'b0;
        // Word lands about five clocks after the rise
        #90 d = i_data;
        #20;
    end
    endtask
endmodule

// ---- testbench/tb_top.sv ----
// Self-checking testbench for the FIFO memory simulator
`timescale 1ns/10ps

module tb_top
    import fifo_sim_pkg::*;
;
    localparam logic [31:0] MEM  = 32'h0001_0000;
    localparam logic [31:0] CTRL = 32'h0002_0000;
    localparam logic [31:0] CNT  = 32'h0002_0004;
    localparam logic [31:0] STAT = 32'h0002_0008;
    localparam logic [31:0] IST  = 32'h0002_000C;
    localparam logic [31:0] ICLR = 32'h0002_0010;
    localparam logic [31:0] IEN  = 32'h0002_0014;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        bsel = 1'b1;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd, v, ldi, ldo;
    logic        hready, hresp, ack, lo, hi, dir, irq, lclk, lwr, oe, wgate, att;
    logic        s_ack, s_lo, s_hi;
    int          miscompares = 0;
    int          samples_checked = 0;
    int          i;

    always #12.5 clk = ~clk;

    fifo_memory_simulator dut (
        .I_CLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
        .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hready),
        .O_HREADYOUT(hready), .O_HRDATA(hrdata), .O_HRESP(hresp), .I_BOARD_SELECT(bsel),
        .O_HOST_ACK(ack), .O_LANE_LOW_EN(lo), .O_LANE_HIGH_EN(hi), .O_HOST_DIR(dir),
        .O_IRQ(irq), .I_LINK_CLK(lclk), .I_LINK_WRITE(lwr), .I_LINK_DATA(ldi),
        .O_LINK_DATA(ldo), .O_LINK_DATA_OE(oe), .O_LINK_WRITE_GATE(wgate),
        .O_TARGET_ATTENTION(att)
    );

    link_unit lu (.i_data(ldo), .o_clk(lclk), .o_write(lwr), .o_data(ldi));

    task automatic end_sim;
    begin
        $display("checked %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    end
    endtask

    task automatic chkb(input string n, input logic e, input logic g);
    begin
        samples_checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    end
    endtask

    // Single AHB-Lite transfer; ack and lanes are taken at the answering edge
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        int n;
    begin
        @(posedge clk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        n = 0;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 100);
        rd = hrdata;
        s_ack = ack;
        s_lo = lo;
        s_hi = hi;
        if (n >= 100)
            miscompares++;
    end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    begin
        bus(1'b0, a, 32'h0);
        chk(n, e, rd);
    end
    endtask

    initial
    begin
        #1_000_000;
        miscompares++;
        end_sim();
    end

    initial
    begin
        repeat (5) @(posedge clk);
        chkb("hready reset", 1'b1, hready);
        chkb("irq reset", 1'b0, irq);
        chkb("ack reset", 1'b0, ack);
        rst <= 1'b0;
        rchk("control reset", CTRL, 32'h0);
        rchk("irq enable reset", IEN, 32'h0);
        $display("test reset done");

        wr(CTRL, 32'h1);
        for (i = 0; i < 4; i++)
            wr(MEM + 32'(i / 2 * 2044 + i) * 4, 32'hA5A5_0000 + i);
        chkb("write ack", 1'b1, s_ack);
        chkb("write direction", 1'b0, dir);
        chkb("okay response", 1'b0, hresp);
        chkb("low lane", 1'b1, s_lo);
        chkb("high lane", 1'b1, s_hi);
        for (i = 0; i < 4; i++)
            rchk("host word", MEM + 32'(i / 2 * 2044 + i) * 4, 32'hA5A5_0000 + i);
        chkb("read ack", 1'b1, s_ack);
        @(posedge clk);
        chkb("read direction", 1'b1, dir);
        rchk("unmapped", 32'h0003_0000, 32'h0);
        chkb("unmapped ack", 1'b0, s_ack);
        bsel <= 1'b0;
        wr(MEM, 32'hDEAD_BEEF);
        rchk("deselected", MEM, 32'h0);
        chkb("deselected ack", 1'b0, s_ack);
        bsel <= 1'b1;
        rchk("word kept", MEM, 32'hA5A5_0000);
        $display("test host access done");

        wr(CTRL, 32'h0);
        wr(CNT, 32'h1);
        rchk("counter cleared", CNT, 32'h0);
        for (i = 0; i < 6; i++)
            lu.put(32'hC0DE_0000 + i);
        repeat (8) @(posedge clk);
        rchk("counter step", CNT, 32'h6);
        chkb("write gate", 1'b1, wgate);
        chkb("oe idle", 1'b0, oe);
        rchk("irq status", IST, 32'h2);
        chkb("irq masked", 1'b0, irq);
        wr(CTRL, 32'h1);
        for (i = 0; i < 6; i++)
            rchk("link stored", MEM + 32'(i) * 4, 32'hC0DE_0000 + i);
        wr(IEN, 32'h2);
        rchk("irq enable", IEN, 32'h2);
        chkb("irq raised", 1'b1, irq);
        wr(ICLR, 32'h7);
        rchk("irq cleared", IST, 32'h0);
        chkb("irq low", 1'b0, irq);
        $display("test link write done");

        wr(CTRL, 32'h0);
        wr(CNT, 32'h1);
        for (i = 0; i < 3; i++)
        begin
            lu.get(v);
            chk("link read", 32'hC0DE_0000 + i, v);
        end
        repeat (8) @(posedge clk);
        chkb("oe reading", 1'b1, oe);
        chkb("gate reading", 1'b0, wgate);
        rchk("counter reads", CNT, 32'h3);
        rchk("read status", IST, 32'h4);
        wr(ICLR, 32'h7);
        wr(CTRL, 32'h52);
        wr(CNT, 32'h1);
        lu.get(v);
        chk("nibble select", 32'hC0DE_0005, v);
        $display("test link read done");

        wr(CTRL, 32'h102);
        rchk("status", STAT, 32'h1001);
        chkb("attention", 1'b1, att);
        wr(CTRL, 32'h0);
        rchk("control", CTRL, 32'h0);
        chkb("attention off", 1'b0, att);
        wr(MEM + 32'h40, 32'h600D_F00D);
        rchk("counter mode step", CNT, 32'h2);
        wr(CTRL, 32'h1);
        rchk("counter mode word", MEM + 32'h4, 32'h600D_F00D);
        $display("test status done");

        wr(IEN, 32'h1);
        wr(CNT, 32'h1);
        for (i = 0; i < 2048; i++)
            lu.put(32'(i));
        repeat (8) @(posedge clk);
        rchk("counter full", CNT, 32'h800);
        rchk("status full", STAT, 32'h800);
        chkb("full irq", 1'b1, irq);
        chkb("full attention", 1'b1, att);
        lu.put(32'h1234_5678);
        repeat (8) @(posedge clk);
        rchk("counter held", CNT, 32'h800);
        wr(CTRL, 32'h1);
        rchk("last word", MEM + 32'h1FFC, 32'h7FF);
        wr(CNT, 32'h1);
        rchk("counter reset", CNT, 32'h0);
        $display("test full done");
        end_sim();
    end
endmodule
